/* File: hdl/efr_event_id_regs.v */
// Event status register and die identification registers
`timescale 1ns/1ps
`default_nettype none
`include "efr_map.vh"

// Function
// - Bit 7 latches low-battery current cut events since last read.
// - Bit 6 latches input limit reached during transmit blanking since read.
// - Status bits 5 down to 0 always read zero.
// - Flags held until read, cleared by read, set again if cause persists.
// - Die type register returns two BCD digits in high and low nibbles.
// - ID registers are constants, independent of reset and writes.
// - Variant nibble is BCD, zero means plain variant.
// - Low nibble of second ID register is BCD mask revision.
module efr_event_id_regs (
   input  wire       mclk_i,
   input  wire       reset_n_i,
   input  wire       low_battery_current_cut_i,
   input  wire       blank_input_limit_i,
   input  wire       reg_rd_i,
   input  wire       reg_wr_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   output wire       lowbatt_cut_event_flag_o,
   output wire       blank_input_limit_flag_o
);

   // ==========================================================
   // Reset release
   // Asserts at once, releases on a clock edge, so that every
   // flop below leaves reset on the same edge
   reg                         rst_meta_n;
   reg                         rst_n;

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_n <= `EFR_LEVEL_LOW;
      end else begin
         rst_meta_n <= `EFR_LEVEL_HIGH;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_n <= `EFR_LEVEL_LOW;
      end else begin
         rst_n <= rst_meta_n;
      end
   end

   // ==========================================================
   // Event inputs
   // Both causes come from the analog side, with no relation
   // to mclk_i; they are levels, not pulses
   wire [`EFR_EVENT_COUNT-1:0] ev_raw;
   wire [`EFR_EVENT_COUNT-1:0] ev_flag;

   assign ev_raw[`EFR_EVENT_LOWBATT] = low_battery_current_cut_i;
   assign ev_raw[`EFR_EVENT_BLANK]   = blank_input_limit_i;

   // ==========================================================
   // Read decode
   wire                        rd_status;
   wire                        rd_die_type;
   wire                        rd_variant;

   assign rd_status   = reg_rd_i &
                        (reg_addr_i == `EFR_ADDR_EVENT_FLAGS);
   assign rd_die_type = reg_rd_i &
                        (reg_addr_i == `EFR_ADDR_DIE_TYPE);
   assign rd_variant  = reg_rd_i &
                        (reg_addr_i == `EFR_ADDR_VARIANT_REV);

   // ==========================================================
   // Sticky flags, one slice per event
   genvar gi;

   generate
      for (gi = 0; gi < `EFR_EVENT_COUNT; gi = gi + 1) begin : g_event
         reg  meta;
         reg  sync;
         reg  flag;
         wire next_flag;

         // First synchroniser stage; nothing but sync reads it
         always @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               meta <= `EFR_LEVEL_LOW;
            end else begin
               meta <= ev_raw[gi];
            end
         end

         // Second synchroniser stage
         always @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               sync <= `EFR_LEVEL_LOW;
            end else begin
               sync <= meta;
            end
         end

         // Set wins over the read clear, so an event in the
         // read cycle is never lost; writes have no path here
         assign next_flag = sync | (flag & ~rd_status);

         always @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               flag <= `EFR_LEVEL_LOW;
            end else begin
               flag <= next_flag;
            end
         end

         assign ev_flag[gi] = flag;
      end
   endgenerate

   // ==========================================================
   // Register words
   wire [7:0]                  status_word;
   wire [7:0]                  die_type_word;
   wire [7:0]                  variant_rev_word;

   assign status_word[`EFR_BIT_LOWBATT_CUT] =
          ev_flag[`EFR_EVENT_LOWBATT];
   assign status_word[`EFR_BIT_BLANK_ILIM] =
          ev_flag[`EFR_EVENT_BLANK];
   assign status_word[`EFR_RSVD_MSB:`EFR_RSVD_LSB] =
          `EFR_RSVD_ZERO;

   // Hardwired: no reset and no write reaches these words
   assign die_type_word    = {`EFR_DIE_TYPE_HI,
                              `EFR_DIE_TYPE_LO};
   assign variant_rev_word = {`EFR_VARIANT_PLAIN,
                              `EFR_REVISION_CODE};

   // ==========================================================
   // Read data mux
   // Idle cycles and unmapped addresses both give zero, so a
   // host that samples late sees zero, never stale data
   reg  [7:0]                  next_rdata;

   always @* begin
      next_rdata = `EFR_READ_IDLE;
      if (rd_status) begin
         next_rdata = status_word;
      end else if (rd_die_type) begin
         next_rdata = die_type_word;
      end else if (rd_variant) begin
         next_rdata = variant_rev_word;
      end else begin
         next_rdata = `EFR_READ_IDLE;
      end
   end

   // ==========================================================
   // Read data register
   // The flag value is taken on the same edge that clears it,
   // so the host always sees the pre-clear value
   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= `EFR_READ_IDLE;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

   // ==========================================================
   // Flag outputs
   assign lowbatt_cut_event_flag_o = ev_flag[`EFR_EVENT_LOWBATT];
   assign blank_input_limit_flag_o = ev_flag[`EFR_EVENT_BLANK];

   // ==========================================================
   // Host writes
   // Every register of this bank is read-only: reg_wr_i and
   // reg_wdata_i reach no logic, so a write can neither change
   // a code nor clear a pending flag

endmodule // efr_event_id_regs
`default_nettype wire

/* File: include/efr_map.vh */
// Register offsets, field positions and code constants for the event/ID bank
`ifndef EFR_MAP_VH
`define EFR_MAP_VH
`define EFR_ADDR_EVENT_FLAGS   8'h18
`define EFR_ADDR_DIE_TYPE      8'h1a
`define EFR_ADDR_VARIANT_REV   8'h1b
`define EFR_BIT_LOWBATT_CUT    7
`define EFR_BIT_BLANK_ILIM     6
`define EFR_RSVD_ZERO          6'h00
`define EFR_READ_IDLE          8'h00
`define EFR_RSVD_MSB           5
`define EFR_RSVD_LSB           0
`define EFR_EVENT_COUNT        2
`define EFR_EVENT_LOWBATT      1
`define EFR_EVENT_BLANK        0
`define EFR_LEVEL_LOW          1'b0
`define EFR_LEVEL_HIGH         1'b1
// Identity codes: arbitrary neutral values, BCD digits
`define EFR_DIE_TYPE_HI        4'h4
`define EFR_DIE_TYPE_LO        4'h2
`define EFR_VARIANT_PLAIN      4'h0
`define EFR_REVISION_CODE      4'h3
`endif

/* File: tb/efr_event_id_regs_assertions.sv */
// Checker for the event and identity registers
`timescale 1ns/1ps
`default_nettype none
module efr_chk(input wire mclk_i,reset_n_i,reg_rd_i,reg_wr_i,
   low_battery_current_cut_i,blank_input_limit_i,lowbatt_cut_event_flag_o,
   blank_input_limit_flag_o,input wire [7:0] reg_addr_i,reg_wdata_i,reg_rdata_o);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire [7:0] a=reg_addr_i,q=reg_rdata_o;
   wire r=reg_rd_i,s=r&&a==8'h18,e=low_battery_current_cut_i,
      f=lowbatt_cut_event_flag_o,b=blank_input_limit_flag_o;
   a_rsvd_zero: assert property(s|=>q[5:0]==0)else $error("rsvd");
   a_die_type: assert property(r&&a==8'h1a|=>q==8'h42)
      else $error("id1");
   a_variant_code: assert property(r&&a==8'h1b|=>q==8'h03)
      else $error("id2");
   a_idle_zero: assert property(!r|=>q==0)else $error("idle");
   a_flag_read: assert property(s|=>q[7:6]=={$past(f),$past(b)})
      else $error("flags");
   a_event_set: assert property(e|->##[1:3]f)else $error("set");
   a_read_clr: assert property((!e)[*4]##0 s|=>!f)else $error("clr");
   a_flag_hold: assert property(f&&!s|=>f)else $error("hold");
   c_rd: cover property(s&&f);
   c_bl: cover property(s&&b);
   c_wr: cover property(reg_wr_i&&f);
endmodule // efr_chk
bind efr_event_id_regs efr_chk u_chk(.*);
`default_nettype wire

/* File: tb/efr_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module efr_host(input wire mclk_i,input wire [7:0] reg_rdata_o,
   output logic reg_rd_i=0,reg_wr_i=0,
   output logic [7:0] reg_addr_i=0,reg_wdata_i=0);
   // Strobe one cycle, answer taken the cycle after
   task acc(input r,input [7:0] x,output [7:0] d);
      @(negedge mclk_i) {reg_rd_i,reg_wr_i,reg_addr_i,reg_wdata_i}={r,!r,x,~x};
      @(negedge mclk_i) {reg_rd_i,reg_wr_i,d}={2'b00,reg_rdata_o};
   endtask
endmodule // efr_host
`default_nettype wire

/* File: tb/efr_event_id_regs_test.sv */
// Testbench for the event and identity registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin samples_checked++; if ((a)!==(e)) begin \
   miscompares++; $display("[ERR] %0t %h %h",$time,a,e); end end
module efr_event_id_regs_test;
   logic mclk_i=0,reset_n_i=0,reg_rd_i,reg_wr_i,lowbatt_cut_event_flag_o;
   logic low_battery_current_cut_i=0,blank_input_limit_i=0,blank_input_limit_flag_o;
   logic [7:0] reg_addr_i,reg_wdata_i,reg_rdata_o,d;
   int miscompares=0,samples_checked=0;
   initial forever #50 mclk_i=~mclk_i;
   efr_host h(.*);
   efr_event_id_regs uut(.*);
   task conclude;
      $display("checked %0d mismatched %0d",samples_checked,miscompares);
      if (miscompares==0&&samples_checked>0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin #20000 miscompares++; conclude; end
   initial begin
      #800 reset_n_i=1;
      #400 h.acc(1,8'h1a,d); `CHK(d,8'h42)
      h.acc(1,8'h1b,d); `CHK(d,8'h03)
      h.acc(1,8'h19,d); `CHK(d,8'h00)
      $display("id test done");
      {low_battery_current_cut_i,blank_input_limit_i}=2'h3;
      #500 low_battery_current_cut_i=0;
      h.acc(0,8'h18,d);
      `CHK({lowbatt_cut_event_flag_o,blank_input_limit_flag_o},2'h3)
      #300 h.acc(1,8'h18,d); `CHK(d,8'hc0)
      h.acc(1,8'h18,d); `CHK(d,8'h40)
      blank_input_limit_i=0;
      #400 h.acc(1,8'h18,d); `CHK(d,8'h40)
      h.acc(1,8'h18,d); `CHK(d,8'h00)
      `CHK({lowbatt_cut_event_flag_o,blank_input_limit_flag_o},2'h0)
      $display("register test done");
      conclude;
   end
endmodule // efr_event_id_regs_test
`default_nettype wire
